// [logic/rsse_core.sv]
// Executor for rotate-right, set-all-ones and sleep instructions
`default_nettype none
module rsse_core
   import rsse_pkg::*;
(
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_n_in,
   // APB slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Program memory
   input wire logic [15:0] instr_in,
   input wire logic instr_valid_in,
   output logic fetch_out,
   // Watchdog and wake-up
   input wire logic wdt_tick_in,
   input wire logic wake_wdt_in,
   input wire logic wake_event_in,
   output logic wdt_clear_out,
   output logic sleep_out
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   rsse_phase_e phase_r, phase_nxt;   // Instruction phase
   rsse_op_e op_r;                    // Decoded operation
   logic sleep_r, sleep_nxt;          // Oscillator stopped
   logic [15:0] instr_r;              // Latched instruction word
   logic [7:0] opnd_r;                // Operand read in phase two
   logic [7:0] res;                   // Result of the process phase
   logic [7:0] w_r;                   // Working accumulator
   logic zero_r, neg_r;               // Arithmetic flags
   logic power_down_flag_r;           // Cleared by sleep
   logic timeout_flag_r;              // Set by sleep, cleared by wdt wake
   logic ext_en_r;                    // Extended instruction set
   logic [3:0] bank_select_register_r; // Bank for a=1
   logic [11:0] idx_base_r;           // Base for indexed offsets
   logic [7:0] watchdog_counter_r;    // Watchdog count
   logic [3:0] wdt_post_r;            // Watchdog postscaler
   logic [11:0] maddr_r;              // Memory window address
   logic mpend_r;                     // Window access in flight
   logic [11:0] eff_addr;             // Operand address
   logic do_q4;                       // Final phase while awake
   logic sleep_exec;                  // Sleep executing now
   logic wr_file;                     // File write back this cycle
   logic apb_acc, apb_slot, apb_mem_go, wr_fire;
   logic mapped;
   logic [31:0] rd_data;

   rsse_mem_if mif();

   rsse_data_mem u_mem (
      .mclk_in(mclk_in),
      .port(mif.mem)
   );

   // ---------------------------------------------------------------
   // Phase sequencing
   // ---------------------------------------------------------------
   // Next phase; the sequence halts at the first phase while asleep
   always_comb begin
      phase_nxt = phase_r;
      sleep_nxt = sleep_r;
      if (sleep_r) begin
         // Any wake source restarts the clock
         if (wake_wdt_in || wake_event_in) begin
            sleep_nxt = 1'b0;
         end
      end else begin
         case (phase_r)
            PH_Q1: phase_nxt = PH_Q2;
            PH_Q2: phase_nxt = PH_Q3;
            PH_Q3: phase_nxt = PH_Q4;
            PH_Q4: begin
               phase_nxt = PH_Q1;
               // Stop in the last phase of the halt cycle
               if (op_r == OP_SLEEP) begin
                  sleep_nxt = 1'b1;
               end
            end
            default: phase_nxt = PH_Q1;
         endcase
      end
   end

   assign do_q4 = !sleep_r && phase_r == PH_Q4;
   assign sleep_exec = do_q4 && op_r == OP_SLEEP;

   // Phase and sleep flops
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         phase_r <= PH_Q1;
         sleep_r <= 1'b0;
         sleep_out <= 1'b0;
         fetch_out <= 1'b1;
      end else begin
         phase_r <= phase_nxt;
         sleep_r <= sleep_nxt;
         sleep_out <= sleep_nxt;
         fetch_out <= phase_nxt == PH_Q1 && !sleep_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Decode, operand read, process
   // ---------------------------------------------------------------
   // Phase one decodes; an absent word executes as no operation
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         op_r <= OP_NONE;
         instr_r <= 16'h0000;
      end else if (!sleep_r && phase_r == PH_Q1) begin
         instr_r <= instr_in;
         if (!instr_valid_in) begin
            op_r <= OP_NONE;
         end else if (instr_in[15:10] == OPC_ROT) begin
            op_r <= OP_ROT;
         end else if (instr_in[15:9] == OPC_SET) begin
            op_r <= OP_SET;
         end else if (instr_in == OPC_SLEEP) begin
            op_r <= OP_SLEEP;
         end else begin
            op_r <= OP_NONE;
         end
      end
   end

   // Operand address, shared by the read and the write back
   assign eff_addr = rsse_eff_addr(instr_r[7:0], instr_r[A_BIT],
      ext_en_r, bank_select_register_r, idx_base_r);

   // Memory answers the phase-two read during phase three
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         opnd_r <= 8'h00;
      end else if (!sleep_r && phase_r == PH_Q3) begin
         opnd_r <= mif.rdata;
      end
   end

   // Set writes a constant; rotate wraps the operand
   assign res = (op_r == OP_SET) ? ALL_ONES : rsse_rotr(opnd_r);
   assign wr_file = do_q4 && ((op_r == OP_ROT && instr_r[D_BIT]) ||
      op_r == OP_SET);

   // ---------------------------------------------------------------
   // Memory port sharing
   // ---------------------------------------------------------------
   // Core owns phases two and four; software uses the others
   assign apb_slot = sleep_r || phase_r == PH_Q1 || phase_r == PH_Q3;
   assign apb_acc = psel_in && penable_in && !pready_out;
   assign apb_mem_go = apb_acc && !mpend_r && paddr_in == REG_MDATA &&
      apb_slot;

   always_comb begin
      mif.addr = eff_addr;
      mif.we = wr_file;
      mif.wdata = res;
      if (apb_mem_go) begin
         mif.addr = maddr_r;
         mif.we = pwrite_in;
         mif.wdata = pwdata_in[7:0];
      end
   end

   // ---------------------------------------------------------------
   // Accumulator and flags
   // ---------------------------------------------------------------
   // A rotate to W beats a software write in the same cycle
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         w_r <= 8'h00;
      end else if (do_q4 && op_r == OP_ROT && !instr_r[D_BIT]) begin
         w_r <= res;
      end else if (wr_fire && paddr_in == REG_WREG) begin
         w_r <= pwdata_in[7:0];
      end
   end

   // Only the rotate touches N and Z
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         zero_r <= 1'b0;
         neg_r <= 1'b0;
      end else if (do_q4 && op_r == OP_ROT) begin
         zero_r <= res == 8'h00;
         neg_r <= res[7];
      end
   end

   // Power-down and time-out flags
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         power_down_flag_r <= PD_RST;
         timeout_flag_r <= TO_RST;
      end else if (sleep_exec) begin
         power_down_flag_r <= 1'b0;
         timeout_flag_r <= 1'b1;
      end else if (sleep_r && wake_wdt_in) begin
         timeout_flag_r <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Watchdog count
   // ---------------------------------------------------------------
   // Keeps counting in sleep, since only the phase sequence stops
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         watchdog_counter_r <= 8'h00;
         wdt_post_r <= 4'h0;
         wdt_clear_out <= 1'b0;
      end else begin
         wdt_clear_out <= sleep_exec;
         if (sleep_exec) begin
            watchdog_counter_r <= 8'h00;
            wdt_post_r <= 4'h0;
         end else if (wdt_tick_in) begin
            wdt_post_r <= wdt_post_r + 4'h1;
            if (wdt_post_r == POST_MAX) begin
               watchdog_counter_r <= watchdog_counter_r + 8'h01;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Register file
   // ---------------------------------------------------------------
   // Writes land at the edge where the master sees ready
   assign wr_fire = psel_in && penable_in && pwrite_in && pready_out;

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         ext_en_r <= 1'b0;
         bank_select_register_r <= 4'h0;
         idx_base_r <= 12'h000;
         maddr_r <= 12'h000;
      end else if (wr_fire) begin
         case (paddr_in)
            REG_CTRL: ext_en_r <= pwdata_in[CTRL_EXT];
            REG_BANK: bank_select_register_r <= pwdata_in[3:0];
            REG_INDEX: idx_base_r <= pwdata_in[11:0];
            REG_MADDR: maddr_r <= pwdata_in[11:0];
            default: ;
         endcase
      end
   end

   // Read view of every register except the memory window data
   always_comb begin
      rd_data = 32'h0000_0000;
      mapped = 1'b1;
      case (paddr_in)
         REG_CTRL: rd_data[CTRL_EXT] = ext_en_r;
         REG_BANK: rd_data[3:0] = bank_select_register_r;
         REG_INDEX: rd_data[11:0] = idx_base_r;
         REG_STATUS: begin
            rd_data[ST_ZERO] = zero_r;
            rd_data[ST_NEG] = neg_r;
            rd_data[ST_PD] = power_down_flag_r;
            rd_data[ST_TO] = timeout_flag_r;
            rd_data[ST_SLEEP] = sleep_r;
         end
         REG_WREG: rd_data[7:0] = w_r;
         REG_WDOG: begin
            rd_data[7:0] = watchdog_counter_r;
            rd_data[WD_POST_LSB +: 4] = wdt_post_r;
         end
         REG_MADDR: rd_data[11:0] = maddr_r;
         default: mapped = 1'b0;
      endcase
   end

   // One wait state for registers, a free memory slot for the window
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out <= 32'h0000_0000;
         mpend_r <= 1'b0;
      end else begin
         mpend_r <= apb_mem_go;
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
         if (mpend_r) begin
            pready_out <= 1'b1;
            prdata_out <= {24'h000000, mif.rdata};
         end else if (apb_acc && paddr_in != REG_MDATA) begin
            pready_out <= 1'b1;
            pslverr_out <= !mapped;
            prdata_out <= rd_data;
         end
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);

   // Flags are checked against the operand, not against the result
   property p_rot_value;
      do_q4 && op_r == OP_ROT |-> mif.wdata == {opnd_r[0], opnd_r[7:1]} ##1
         zero_r == (opnd_r == 8'h00) && neg_r == opnd_r[0];
   endproperty
   a_rot_value: assert property (p_rot_value)
      else $error("rotate result wrong");

   property p_rot_dest;
      do_q4 && op_r == OP_ROT && !instr_r[D_BIT] |-> !mif.we ##1
         w_r == $past(res) && zero_r == (w_r == 8'h00) && neg_r == w_r[7];
   endproperty
   a_rot_dest: assert property (p_rot_dest)
      else $error("rotate to accumulator wrong");

   property p_access_bank;
      !sleep_r && phase_r == PH_Q2 && !instr_r[A_BIT] &&
         !(ext_en_r && instr_r[7:0] <= IDX_LIMIT) |->
         mif.addr == ((instr_r[7:0] < ACC_SPLIT) ? {4'h0, instr_r[7:0]} :
         {ACC_HIGH_BANK, instr_r[7:0]});
   endproperty
   a_access_bank: assert property (p_access_bank)
      else $error("access bank address wrong");

   property p_bank_sel;
      !sleep_r && phase_r == PH_Q2 && instr_r[A_BIT] |->
         mif.addr == {bank_select_register_r, instr_r[7:0]};
   endproperty
   a_bank_sel: assert property (p_bank_sel)
      else $error("banked address wrong");

   property p_indexed;
      !sleep_r && phase_r == PH_Q2 && !instr_r[A_BIT] && ext_en_r &&
         instr_r[7:0] <= IDX_LIMIT |->
         mif.addr == idx_base_r + {4'h0, instr_r[7:0]};
   endproperty
   a_indexed: assert property (p_indexed)
      else $error("indexed address wrong");

   property p_set;
      do_q4 && op_r == OP_SET |-> mif.we && mif.wdata == ALL_ONES ##1
         zero_r == $past(zero_r) && neg_r == $past(neg_r);
   endproperty
   a_set: assert property (p_set)
      else $error("set-all-ones wrong");

   property p_pd;
      sleep_exec |=> !power_down_flag_r && sleep_out;
   endproperty
   a_pd: assert property (p_pd)
      else $error("power-down flag not cleared");

   property p_to;
      sleep_exec |=> timeout_flag_r && $rose(sleep_r);
   endproperty
   a_to: assert property (p_to)
      else $error("time-out flag not set");

   property p_wdt;
      sleep_exec |=> watchdog_counter_r == 8'h00 && wdt_post_r == 4'h0 &&
         wdt_clear_out ##1 !wdt_clear_out;
   endproperty
   a_wdt: assert property (p_wdt)
      else $error("watchdog not cleared");

   property p_wake;
      sleep_r && wake_wdt_in |=> !timeout_flag_r && !sleep_r && fetch_out;
   endproperty
   a_wake: assert property (p_wake)
      else $error("watchdog wake wrong");

   property p_cycle;
      !sleep_r && phase_r == PH_Q1 |=> phase_r == PH_Q2 ##1
         phase_r == PH_Q3 ##1 phase_r == PH_Q4 ##1 phase_r == PH_Q1;
   endproperty
   a_cycle: assert property (p_cycle)
      else $error("phase sequence broken");

endmodule
`default_nettype wire

// [logic/rsse_pkg.sv]
// Shared constants, types and helpers for the rotate/set/sleep executor
`default_nettype none
package rsse_pkg;

   // ---------------------------------------------------------------
   // Instruction encodings
   // ---------------------------------------------------------------
   localparam logic [5:0] OPC_ROT = 6'h10;     // Upper six bits, rotate
   localparam logic [6:0] OPC_SET = 7'h34;     // Upper seven bits, set
   localparam logic [15:0] OPC_SLEEP = 16'h0003; // Whole word, halt
   localparam int D_BIT = 9;                   // Destination select bit
   localparam int A_BIT = 8;                   // Bank access bit

   // ---------------------------------------------------------------
   // Data memory addressing
   // ---------------------------------------------------------------
   localparam logic [7:0] IDX_LIMIT = 8'h5F;   // Highest indexed offset
   localparam logic [7:0] ACC_SPLIT = 8'h60;   // Access bank low/high split
   localparam logic [3:0] ACC_HIGH_BANK = 4'hF; // Bank of upper access part
   localparam logic [7:0] ALL_ONES = 8'hFF;    // Set-all-ones value

   // ---------------------------------------------------------------
   // Register offsets (byte addresses) and field positions
   // ---------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;    // Extended set enable
   localparam logic [7:0] REG_BANK = 8'h04;    // Bank select
   localparam logic [7:0] REG_INDEX = 8'h08;   // Indexed base pointer
   localparam logic [7:0] REG_STATUS = 8'h0C;  // Flags, read only
   localparam logic [7:0] REG_WREG = 8'h10;    // Working accumulator
   localparam logic [7:0] REG_WDOG = 8'h14;    // Watchdog state, read only
   localparam logic [7:0] REG_MADDR = 8'h18;   // Data memory window address
   localparam logic [7:0] REG_MDATA = 8'h1C;   // Data memory window data
   localparam int CTRL_EXT = 0;                // Extended set enable bit
   localparam int ST_ZERO = 0;                 // Zero flag
   localparam int ST_NEG = 1;                  // Negative flag
   localparam int ST_PD = 2;                   // Power-down flag
   localparam int ST_TO = 3;                   // Time-out flag
   localparam int ST_SLEEP = 4;                // Sleeping
   localparam int WD_POST_LSB = 8;             // Postscaler field position

   // ---------------------------------------------------------------
   // Reset values and postscaler carry point
   // ---------------------------------------------------------------
   localparam logic PD_RST = 1'b1;             // Power-down flag at reset
   localparam logic TO_RST = 1'b1;             // Time-out flag at reset
   localparam logic [3:0] POST_MAX = 4'hF;     // Postscaler carry point

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} rsse_phase_e;
   typedef enum logic [1:0] {OP_NONE, OP_ROT, OP_SET, OP_SLEEP} rsse_op_e;

   // Rotate right one place, bit 0 wraps into bit 7
   function automatic logic [7:0] rsse_rotr(input logic [7:0] v);
      return {v[0], v[7:1]};
   endfunction

   // Effective data memory address of a file operand
   function automatic logic [11:0] rsse_eff_addr(input logic [7:0] f,
         input logic a, input logic ext, input logic [3:0] bank,
         input logic [11:0] idx);
      if (!a && ext && f <= IDX_LIMIT) begin
         return idx + {4'h0, f};
      end else if (!a) begin
         return (f < ACC_SPLIT) ? {4'h0, f} : {ACC_HIGH_BANK, f};
      end
      return {bank, f};
   endfunction

endpackage
`default_nettype wire

// [logic/rsse_mem_if.sv]
// Port bundle between the executor and its data memory
`default_nettype none
interface rsse_mem_if;
   logic [11:0] addr;   // Byte address
   logic we;            // Write strobe
   logic [7:0] wdata;   // Write data
   logic [7:0] rdata;   // Registered read data
   modport core (output addr, output we, output wdata, input rdata);
   modport mem (input addr, input we, input wdata, output rdata);
endinterface
`default_nettype wire

// [logic/rsse_data_mem.sv]
// Data memory of 16 banks, registered read port
`default_nettype none
module rsse_data_mem (
   // Clock
   input wire logic mclk_in,
   // Access port
   rsse_mem_if.mem port
);

   // Storage, no reset: contents are undefined until written
   logic [7:0] mem_r [0:4095];

   // ---------------------------------------------------------------
   // Write and registered read
   // ---------------------------------------------------------------
   always_ff @(posedge mclk_in) begin
      if (port.we) begin
         mem_r[port.addr] <= port.wdata;
      end
   end

   // Read data are the word addressed at the previous edge
   always_ff @(posedge mclk_in) begin
      port.rdata <= mem_r[port.addr];
   end

endmodule
`default_nettype wire

// [verification/rsse_prog_mem.sv]
// Program memory model that hands instruction words to the executor
`default_nettype none
module rsse_prog_mem (
   // Clock and fetch request
   input wire logic mclk_in,
   input wire logic fetch_in,
   // Instruction word
   output logic [15:0] instr_out,
   output logic instr_valid_out,
   output logic [7:0] taken_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // ---------------------------------------------------------------
   // Word queue
   // ---------------------------------------------------------------
   logic [15:0] q[$];            // Words waiting for a fetch
   logic [15:0] head_r = 16'h0000; // Word on offer
   logic have_r = 1'b0;          // A word is on offer
   logic [7:0] taken_r = 8'h00;  // Words taken so far
   // Queue a word for a later fetch
   task automatic push(input logic [15:0] w);
      q.push_back(w);
   endtask
   // A word leaves at the edge that closes the fetch phase
   always @(posedge mclk_in) begin
      if (fetch_in && have_r) begin
         void'(q.pop_front());
         taken_r <= taken_r + 8'h01;
      end
      have_r <= (q.size() != 0);
      head_r <= (q.size() != 0) ? q[0] : ~head_r;
   end
   // Outside a fetch the bus shows the inverse, never a stale word
   assign instr_out = fetch_in ? head_r : ~head_r;
   assign instr_valid_out = fetch_in & have_r;
   assign taken_out = taken_r;
endmodule
`default_nettype wire

// [verification/tb_top.sv]
// Self-checking bench for the rotate/set/sleep executor
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import rsse_pkg::*;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   typedef struct {
      logic [15:0] w;
      logic ext;
      logic [3:0] bank;
      logic [11:0] addr;
      logic [7:0] init, mem, wreg;
      logic [1:0] nz;
   } rsse_row_s;
   logic mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, pready, pslverr, instr_valid, fetch;
   logic [7:0] paddr = 8'h00, taken;
   logic [31:0] pwdata = 32'h0, prdata, rd_v;
   logic [15:0] instr;
   logic wdt_tick = 1'b0, wake_wdt = 1'b0, wake_event = 1'b0;
   logic wdt_clear, sleep;
   int miscompares = 0, checks = 0, cyc = 0;
   // Rows: word, ext, bank, effective address, before, after, W, {N,Z}
   rsse_row_s rows [8] = '{
      '{16'h4325, 1'b0, 4'h3, 12'h325, 8'hD7, 8'hEB, 8'h11, 2'b10},
      '{16'h6844, 1'b0, 4'h3, 12'h044, 8'h5A, 8'hFF, 8'h11, 2'b10},
      '{16'h405F, 1'b1, 4'h3, 12'h25F, 8'h00, 8'h00, 8'h00, 2'b01},
      '{16'h6933, 1'b1, 4'h7, 12'h733, 8'h5A, 8'hFF, 8'h11, 2'b01},
      '{16'h6810, 1'b1, 4'h7, 12'h210, 8'h00, 8'hFF, 8'h11, 2'b01},
      '{16'h4010, 1'b0, 4'h5, 12'h010, 8'hD7, 8'hD7, 8'hEB, 2'b10},
      '{16'h4280, 1'b0, 4'h5, 12'hF80, 8'h01, 8'h80, 8'h11, 2'b10},
      '{16'h4260, 1'b1, 4'h5, 12'hF60, 8'h02, 8'h01, 8'h11, 2'b00}};
   // ---------------------------------------------------------------
   // Design and program memory
   // ---------------------------------------------------------------
   rsse_core u_rsse_core (.mclk_in(mclk), .rst_n_in(rst_n),
      .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
      .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .instr_in(instr),
      .instr_valid_in(instr_valid), .fetch_out(fetch),
      .wdt_tick_in(wdt_tick), .wake_wdt_in(wake_wdt),
      .wake_event_in(wake_event), .wdt_clear_out(wdt_clear),
      .sleep_out(sleep));
   rsse_prog_mem u_rsse_prog_mem (.mclk_in(mclk), .fetch_in(fetch),
      .instr_out(instr), .instr_valid_out(instr_valid),
      .taken_out(taken));
   // 50 MHz clock
   initial begin
      forever #10 mclk = ~mclk;
   end
   // Hang guard, far above the several hundred cycles the run needs
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         give_verdict();
      end
   end
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic give_verdict();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Compare one value, four-state exact
   task automatic chk(input string nm, input logic [31:0] e,
         input logic [31:0] g);
      checks++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One APB transfer; read data and error land in rd_v and er_v
   logic er_v;
   task automatic apb(input logic wr, input logic [7:0] a,
         input logic [31:0] d);
      int n;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd_v = prdata;
      er_v = pslverr;
      if (n >= 50) begin
         miscompares++;
         $display("ERROR pready expected 1 seen 0");
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Queue a word, return just after the edge that takes it
   task automatic exec(input logic [15:0] w);
      logic [7:0] t0;
      int n;
      t0 = taken;
      u_rsse_prog_mem.push(w);
      n = 0;
      do begin
         @(posedge mclk);
         #1;
         n++;
      end while (taken === t0 && n < 40);
      if (taken === t0) begin
         miscompares++;
         $display("ERROR fetch expected taken seen idle");
      end
   endtask
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (20) @(posedge mclk);
      rst_n <= 1'b1;
      apb(0, REG_STATUS, 0);
      chk("status reset", 32'h0C, rd_v);
      apb(1, REG_STATUS, 32'hFF);
      apb(0, REG_STATUS, 0);
      chk("status read only", 32'h0C, rd_v);
      apb(0, 8'h20, 0);
      chk("unmapped err", 32'h1, {31'h0, er_v});
      $display("reset and map test done");
      foreach (rows[i]) begin
         apb(1, REG_CTRL, {31'h0, rows[i].ext});
         apb(1, REG_BANK, {28'h0, rows[i].bank});
         apb(1, REG_INDEX, 32'h200);
         apb(1, REG_WREG, 32'h11);
         apb(1, REG_MADDR, {20'h0, rows[i].addr});
         apb(1, REG_MDATA, {24'h0, rows[i].init});
         exec(rows[i].w);
         repeat (3) @(posedge mclk);
         apb(0, REG_MDATA, 0);
         chk("mem", {24'h0, rows[i].mem}, rd_v);
         apb(0, REG_WREG, 0);
         chk("wreg", {24'h0, rows[i].wreg}, rd_v);
         apb(0, REG_STATUS, 0);
         chk("nz", {30'h0, rows[i].nz}, {30'h0, rd_v[1:0]});
         $display("row %0d done", i);
      end
      // Near miss of the rotate code, a=0 so it would hit MADDR's byte
      exec(16'h4660);
      repeat (3) @(posedge mclk);
      apb(0, REG_MDATA, 0);
      chk("other opcode", 32'h01, rd_v);
      $display("other opcode test done");
      repeat (19) begin
         @(posedge mclk);
         wdt_tick <= 1'b1;
         @(posedge mclk);
         wdt_tick <= 1'b0;
      end
      apb(0, REG_WDOG, 0);
      chk("wdog count", 32'h301, rd_v);
      exec(OPC_SLEEP);
      repeat (2) @(posedge mclk);
      #1;
      chk("sleep early", 32'h0, {31'h0, sleep});
      @(posedge mclk);
      #1;
      chk("sleep", 32'h1, {31'h0, sleep});
      chk("fetch", 32'h0, {31'h0, fetch});
      chk("wdt clear", 32'h1, {31'h0, wdt_clear});
      @(posedge mclk);
      #1;
      chk("wdt clear end", 32'h0, {31'h0, wdt_clear});
      apb(0, REG_STATUS, 0);
      chk("sleep flags", 32'h6, {29'h0, rd_v[4:2]});
      apb(0, REG_WDOG, 0);
      chk("wdog cleared", 32'h0, rd_v);
      @(posedge mclk);
      wake_wdt <= 1'b1;
      @(posedge mclk);
      wake_wdt <= 1'b0;
      #1;
      chk("wdt wake", 32'h0, {31'h0, sleep});
      apb(0, REG_STATUS, 0);
      chk("wdt wake flags", 32'h0, {29'h0, rd_v[4:2]});
      exec(OPC_SLEEP);
      repeat (3) @(posedge mclk);
      wake_event <= 1'b1;
      @(posedge mclk);
      wake_event <= 1'b0;
      apb(0, REG_STATUS, 0);
      chk("event wake flags", 32'h2, {29'h0, rd_v[4:2]});
      $display("sleep test done");
      @(posedge mclk);
      rst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      apb(0, REG_STATUS, 0);
      chk("status second reset", 32'h0C, rd_v);
      apb(0, REG_WREG, 0);
      chk("wreg second reset", 32'h0, rd_v);
      $display("second reset test done");
      give_verdict();
   end
endmodule
`default_nettype wire
